// file: rtl/crc_pkg.sv
// Constants, carrier types and states for the dual-mode link check block.
package crc_pkg;
  localparam int CRC_W = 16;
  localparam logic [15:0] POLY_BIT = 16'h1021;
  localparam logic [15:0] POLY_BSC = 16'h8005;
  localparam logic [15:0] PRESET_BIT = 16'hFFFF;
  localparam logic [15:0] PRESET_BSC = 16'h0000;
  localparam logic [15:0] RESIDUE_BIT = 16'hF0B8;
  localparam logic [15:0] RESIDUE_BSC = 16'h0000;
  localparam logic [7:0] DELIM_PATTERN = 8'h7E;
  localparam logic [4:0] CHECK_BITS = 5'h10;
  localparam logic [1:0] TRAIL_CHARS = 2'h2;
  // Control character codes
  localparam logic [7:0] SOH_CODE = 8'h01;
  localparam logic [7:0] STX_CODE = 8'h02;
  localparam logic [7:0] ETX_CODE = 8'h03;
  localparam logic [7:0] DLE_CODE = 8'h10;
  localparam logic [7:0] SYN_CODE = 8'h32;

  typedef struct packed {
    logic valid;
    logic data;
    logic flag;
  } bit_in_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } char_in_type;

  typedef enum {ST_IDLE, ST_ACCUM, ST_TRAIL} state_type;
endpackage

// file: rtl/crc_step.sv
// Combinational check update over DW data bits, most significant bit first.
`timescale 1ns/1ns
module crc_step #(
  parameter int DW = 8
) (
  input wire logic [15:0] crc,
  input wire logic [DW-1:0] data,
  input wire logic [15:0] poly,
  output logic [15:0] crc_out
);
  logic [15:0] stage [0:DW];

  assign stage[0] = crc;

  genvar i;
  generate
    for (i = 0; i < DW; i++) begin : g_bit
      wire logic fb = stage[i][15] ^ data[DW-1-i];
      assign stage[i+1] = {stage[i][14:0], 1'b0} ^ (fb ? poly : 16'h0000);
    end
  endgenerate

  assign crc_out = stage[DW];
endmodule

// file: rtl/dual_mode_link_crc.sv
// Dual-mode check generator and checker for bit-oriented and bisync links.
`timescale 1ns/1ns
module dual_mode_link_crc (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Mode select
  input wire logic BISYNC,
  input wire logic TRANSPARENT,
  input wire logic RECEIVE,
  // Serial and character streams from the framing logic
  input wire crc_pkg::bit_in_type BIT_IN,
  input wire crc_pkg::char_in_type CHAR_IN,
  // Transmit check request
  input wire logic CHK_REQ,
  // Check output and status
  output logic CHK_BIT,
  output logic CHK_BIT_VALID,
  output logic CHK_DONE,
  output logic CHK_ERR,
  output logic ACTIVE,
  output logic [15:0] CRC_VALUE
);
  import crc_pkg::*;

  function automatic logic char_is(input logic [7:0] c, input logic [7:0] code);
    return c == code;
  endfunction

  // Register holds x^15 in bit 15; the residue pattern lists x^0 first
  function automatic logic [15:0] reflect16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  state_type state_reg, state_next;
  logic [15:0] crc_reg, crc_next;
  logic [15:0] shift_reg;
  logic [4:0] send_cnt_reg;
  logic [1:0] trail_cnt_reg;
  logic esc_reg;
  logic seen_reg;
  logic [15:0] bit_upd, chr_upd;

  crc_step #(.DW(1)) u_bit_step (
    .crc(crc_reg),
    .data(BIT_IN.data),
    .poly(POLY_BIT),
    .crc_out(bit_upd)
  );

  crc_step #(.DW(8)) u_chr_step (
    .crc(crc_reg),
    .data(CHAR_IN.data),
    .poly(POLY_BSC),
    .crc_out(chr_upd)
  );

  // Bit-oriented decode; the framing logic flags each delimiter
  wire logic bit_mode = !BISYNC;
  wire logic in_accum = state_reg == ST_ACCUM;
  wire logic bit_flag = bit_mode && BIT_IN.flag;
  wire logic bit_feed = bit_mode && in_accum && BIT_IN.valid && !BIT_IN.flag;
  wire logic bit_close = bit_flag && in_accum && seen_reg && RECEIVE;

  // Character decode
  wire logic char_ok = BISYNC && CHAR_IN.valid;
  wire logic is_dle = char_is(CHAR_IN.data, DLE_CODE);
  wire logic is_syn = char_is(CHAR_IN.data, SYN_CODE);
  wire logic is_etx = char_is(CHAR_IN.data, ETX_CODE);
  wire logic is_head = char_is(CHAR_IN.data, SOH_CODE) || char_is(CHAR_IN.data, STX_CODE);
  wire logic chr_start = char_ok && state_reg == ST_IDLE && is_head;
  wire logic chr_acc = char_ok && in_accum;
  wire logic esc_lead = chr_acc && TRANSPARENT && is_dle && !esc_reg;
  wire logic syn_fill = chr_acc && !TRANSPARENT && is_syn;
  wire logic dle_syn = chr_acc && TRANSPARENT && esc_reg && is_syn;
  wire logic chr_feed = chr_acc && !esc_lead && !syn_fill && !dle_syn;
  wire logic etx_end = chr_feed && is_etx && (!TRANSPARENT || esc_reg);
  wire logic trail_feed = char_ok && state_reg == ST_TRAIL && RECEIVE;
  wire logic trail_last = trail_feed && trail_cnt_reg == TRAIL_CHARS - 2'h1;

  // Transmit check hand-off, refused while receiving or while the previous check is still sending
  wire logic can_send = (bit_mode ? in_accum : state_reg == ST_TRAIL) && !RECEIVE;
  wire logic send_go = CHK_REQ && can_send && send_cnt_reg == 5'h00;
  wire logic [15:0] send_value = bit_mode ? ~crc_reg : crc_reg;

  // Evaluation and start events
  wire logic eval = bit_close || trail_last;
  wire logic [15:0] bit_residue = reflect16(crc_reg);
  wire logic eval_bad = bit_close ? bit_residue != RESIDUE_BIT : chr_upd != RESIDUE_BSC;
  wire logic any_start = (bit_flag && !send_go) || chr_start;

  // Delimiter re-presets; checked span is the bits between flags
  assign crc_next = bit_flag ? PRESET_BIT :
                    chr_start ? PRESET_BSC :
                    bit_feed ? bit_upd :
                    (chr_feed || trail_feed) ? chr_upd :
                    crc_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (bit_flag || chr_start) begin
          state_next = ST_ACCUM;
        end
      end
      ST_ACCUM: begin
        if (send_go) begin
          state_next = ST_IDLE;
        end else if (etx_end) begin
          state_next = ST_TRAIL;
        end
      end
      ST_TRAIL: begin
        if (send_go || trail_last) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // Change to bit mode during the bisync trailer abandons the block
    if (bit_mode && state_reg == ST_TRAIL) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      crc_reg <= PRESET_BIT;
      ACTIVE <= 1'b0;
    end else begin
      state_reg <= state_next;
      crc_reg <= crc_next;
      ACTIVE <= state_next == ST_ACCUM;
    end
  end

  // Escape parity: a lone escape arms, the next character disarms
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      esc_reg <= 1'b0;
    end else if (chr_start) begin
      esc_reg <= 1'b0;
    end else if (chr_acc) begin
      esc_reg <= esc_lead;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      seen_reg <= 1'b0;
      trail_cnt_reg <= 2'h0;
    end else begin
      seen_reg <= bit_flag ? 1'b0 : (seen_reg || bit_feed);
      trail_cnt_reg <= etx_end ? 2'h0 : trail_cnt_reg + {1'b0, trail_feed};
    end
  end

  // Serializer, MSB first
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      shift_reg <= 16'h0000;
      send_cnt_reg <= 5'h00;
      CHK_BIT <= 1'b0;
      CHK_BIT_VALID <= 1'b0;
    end else if (send_go) begin
      shift_reg <= send_value;
      send_cnt_reg <= CHECK_BITS;
      CHK_BIT_VALID <= 1'b0;
    end else if (send_cnt_reg != 5'h00) begin
      CHK_BIT <= shift_reg[15];
      CHK_BIT_VALID <= 1'b1;
      shift_reg <= {shift_reg[14:0], 1'b0};
      send_cnt_reg <= send_cnt_reg - 5'h01;
    end else begin
      CHK_BIT_VALID <= 1'b0;
    end
  end

  // Evaluation wins over the clear of the start that shares its cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CHK_DONE <= 1'b0;
      CHK_ERR <= 1'b0;
    end else begin
      CHK_DONE <= eval;
      if (eval) begin
        CHK_ERR <= eval_bad;
      end else if (any_start) begin
        CHK_ERR <= 1'b0;
      end
    end
  end

  assign CRC_VALUE = crc_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_send_burst;
    CHK_BIT_VALID [*8] ##1 CHK_BIT_VALID [*8] ##1 !CHK_BIT_VALID;
  endsequence

  sequence s_bsc_skip;
    (esc_lead || syn_fill || dle_syn) && !trail_feed;
  endsequence

  chk_flag_preset: assert property (bit_flag |=> crc_reg == PRESET_BIT)
    else $error("delimiter did not preset check");
  chk_bit_feed: assert property (bit_feed && !bit_flag |=> crc_reg == $past(bit_upd))
    else $error("checked bit not folded");
  chk_bsc_start: assert property (chr_start |=> crc_reg == PRESET_BSC && ACTIVE)
    else $error("start character mishandled");
  chk_etx_stop: assert property (etx_end |=> state_reg == ST_TRAIL &&
    crc_reg == $past(chr_upd))
    else $error("end of text not included or not stopped");
  chk_esc_skip: assert property (s_bsc_skip |=> $stable(crc_reg))
    else $error("excluded character changed check");
  chk_send_len: assert property (send_go |=> !CHK_BIT_VALID ##1 s_send_burst)
    else $error("check field not 16 bits");
  chk_send_msb: assert property (send_go |=> ##1 CHK_BIT == $past(send_value[15], 2))
    else $error("check not sent MSB first");
  chk_bit_residue: assert property (bit_close |=> CHK_DONE &&
    CHK_ERR == (reflect16($past(crc_reg)) != RESIDUE_BIT))
    else $error("bit residue verdict wrong");
  chk_bsc_residue: assert property (trail_last |=> CHK_DONE &&
    CHK_ERR == ($past(chr_upd) != RESIDUE_BSC))
    else $error("bisync residue verdict wrong");
  chk_err_clear: assert property (any_start && !eval |=> !CHK_ERR)
    else $error("error flag not cleared at start");
endmodule

// file: tb/dual_mode_link_crc_bench.sv
// Self-checking bench for the dual-mode link check block.
`timescale 1ns/1ns
module dual_mode_link_crc_bench;
  import crc_pkg::*;
  logic clk, rst, bisync, transp, receive;
  bit_in_type bit_in;
  char_in_type char_in;
  logic chk_req, chk_bit, chk_bit_valid, chk_done, chk_err, active;
  logic [15:0] crc_value, exp_crc;
  int n_mismatch, total_checks;
  link_seq SEQ (.clk(clk), .bit_in(bit_in), .char_in(char_in), .chk_req(chk_req));
  dual_mode_link_crc DUT (.CLK(clk), .RST(rst), .BISYNC(bisync), .TRANSPARENT(transp),
    .RECEIVE(receive), .BIT_IN(bit_in), .CHAR_IN(char_in), .CHK_REQ(chk_req),
    .CHK_BIT(chk_bit), .CHK_BIT_VALID(chk_bit_valid), .CHK_DONE(chk_done),
    .CHK_ERR(chk_err), .ACTIVE(active), .CRC_VALUE(crc_value));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] step(input logic [15:0] c, input logic d, input logic [15:0] p);
    return {c[14:0], 1'b0} ^ ((c[15] ^ d) ? p : 16'h0000);
  endfunction
  function automatic logic [7:0] rnd_char();
    logic [7:0] c = 8'($urandom);
    return (c inside {SOH_CODE, STX_CODE, ETX_CODE, DLE_CODE, SYN_CODE}) ? c ^ 8'h40 : c;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic bit_tx(input logic d, input logic fold);
    SEQ.send_bit(1'b0, d);
    if (fold) exp_crc = step(exp_crc, d, POLY_BIT);
  endtask
  task automatic char_tx(input logic [7:0] c, input logic fold);
    SEQ.send_char(c);
    for (int i = 7; i >= 0; i--) if (fold) exp_crc = step(exp_crc, c[i], POLY_BSC);
  endtask
  // Pulse is launched on the edge that takes the last unit, so look first
  task automatic verdict(input logic exp_err);
    SEQ.idle();
    for (int i = 0; i < 6; i++) begin
      #1;
      if (chk_done === 1'b1) begin
        check("check error", {15'h0000, chk_err}, {15'h0000, exp_err});
        @(posedge clk);
        #1;
        check("done pulse", {15'h0000, chk_done}, 16'h0000);
        return;
      end
      @(posedge clk);
    end
    check("verdict timeout", 16'h0001, 16'h0000);
    finish_test();
  endtask
  task automatic read_check(input logic [15:0] exp);
    logic [15:0] got;
    SEQ.request();
    SEQ.idle();
    for (int i = 0; i < 6 && chk_bit_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (chk_bit_valid !== 1'b1) begin
      check("burst timeout", 16'h0001, 16'h0000);
      finish_test();
    end
    for (int i = 15; i >= 0; i--) begin
      got[i] = (chk_bit_valid === 1'b1) ? chk_bit : 1'bx;
      @(posedge clk);
      #1;
    end
    check("check bits", got, exp);
    check("burst end", {15'h0000, chk_bit_valid}, 16'h0000);
  endtask
  initial begin
    logic [15:0] fcs;
    rst = 1'b1;
    bisync = 1'b0;
    transp = 1'b0;
    receive = 1'b1;
    exp_crc = 16'h0000;
    n_mismatch = 0;
    total_checks = 0;
    void'($urandom(94027));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("reset crc", crc_value, PRESET_BIT);
    SEQ.send_bit(1'b1, 1'b0);
    // Second frame carries a corrupted check field
    for (int f = 0; f < 2; f++) begin
      exp_crc = PRESET_BIT;
      repeat (8 + $urandom % 40) bit_tx(1'($urandom), 1'b1);
      SEQ.idle();
      #1;
      check("frame crc", crc_value, exp_crc);
      fcs = ~exp_crc ^ (f == 1 ? 16'h0004 : 16'h0000);
      for (int i = 15; i >= 0; i--) bit_tx(fcs[i], 1'b0);
      SEQ.send_bit(1'b1, 1'b0);
      verdict(f == 1);
      check("flag preset", crc_value, PRESET_BIT);
    end
    @(posedge clk);
    receive <= 1'b0;
    SEQ.send_bit(1'b1, 1'b0);
    exp_crc = PRESET_BIT;
    repeat (8 + $urandom % 24) bit_tx(1'($urandom), 1'b1);
    read_check(~exp_crc);
    // Blocks: plain good, plain bad, transparent good
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      bisync <= 1'b1;
      receive <= 1'b1;
      transp <= (k == 2);
      exp_crc = PRESET_BSC;
      char_tx(k == 1 ? SOH_CODE : STX_CODE, 1'b0);
      SEQ.idle();
      #1;
      check("error cleared", {15'h0000, chk_err}, 16'h0000);
      check("start active", {15'h0000, active}, 16'h0001);
      repeat (1 + $urandom % 6) char_tx(rnd_char(), 1'b1);
      if (k == 2) begin
        char_tx(DLE_CODE, 1'b0);
        char_tx(DLE_CODE, 1'b1);
        char_tx(DLE_CODE, 1'b0);
        char_tx(SYN_CODE, 1'b0);
        char_tx(rnd_char(), 1'b1);
        char_tx(DLE_CODE, 1'b0);
      end else begin
        char_tx(SYN_CODE, 1'b0);
        char_tx(rnd_char(), 1'b1);
      end
      char_tx(ETX_CODE, 1'b1);
      fcs = exp_crc ^ (k == 1 ? 16'h0100 : 16'h0000);
      char_tx(fcs[15:8], 1'b0);
      char_tx(fcs[7:0], 1'b0);
      verdict(k == 1);
      check("trail idle", {15'h0000, active}, 16'h0000);
    end
    @(posedge clk);
    receive <= 1'b0;
    transp <= 1'b0;
    exp_crc = PRESET_BSC;
    char_tx(STX_CODE, 1'b0);
    repeat (1 + $urandom % 6) char_tx(rnd_char(), 1'b1);
    char_tx(ETX_CODE, 1'b1);
    read_check(exp_crc);
    // Reset in mid-block drops the block and restores the bit-mode preset
    char_tx(STX_CODE, 1'b0);
    SEQ.idle();
    #1;
    check("tx start active", {15'h0000, active}, 16'h0001);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("mid reset crc", crc_value, PRESET_BIT);
    check("mid reset active", {15'h0000, active}, 16'h0000);
    finish_test();
  end
endmodule

// file: tb/link_seq.sv
// Behavioural frame and character sequencer feeding the check block.
`timescale 1ns/1ns
module link_seq (
  // Clock
  input wire logic clk,
  // Streams toward the check block
  output crc_pkg::bit_in_type bit_in,
  output crc_pkg::char_in_type char_in,
  output logic chk_req
);
  import crc_pkg::*;
  initial begin
    bit_in = '0;
    char_in = '0;
    chk_req = 1'b0;
  end
  // Delimiter travels on flag only, never as a checked bit
  task automatic send_bit(input logic f, input logic d);
    @(posedge clk);
    bit_in <= {~f, d, f};
    char_in.valid <= 1'b0;
  endtask
  task automatic send_char(input logic [7:0] c);
    @(posedge clk);
    char_in <= {1'b1, c};
    bit_in.valid <= 1'b0;
  endtask
  // Released lines show the inverse, so a stale copy cannot pass
  task automatic idle();
    @(posedge clk);
    bit_in <= {1'b0, ~bit_in.data, 1'b0};
    char_in <= {1'b0, ~char_in.data};
    chk_req <= 1'b0;
  endtask
  task automatic request();
    @(posedge clk);
    chk_req <= 1'b1;
    bit_in.valid <= 1'b0;
    char_in.valid <= 1'b0;
  endtask
endmodule
